//--- core/vmc_core.sv
// What this block does
// - code store of 0x800 cells, 40 bits early or 30 bits late.
// - control register holds window address bits 0-10, halt bit 16.
// - code window works only while halted; otherwise reads give zero, writes are dropped.
// - late window access moves bits 0-29 then bumps the address.
// - early cell takes low 32-bit part then high 8-bit part.
// - any control write returns the part toggle to low.
// - low-part access sets toggle high, address unchanged.
// - high-part access uses bits 0-7, toggles low, bumps address.
// - early low write fills shadow; high write stores combined word.
// - reset sets halt bit, core halted with window enabled.
// - halt going 1 to 0 starts execution at address 0.
// - data store of 16-bit cells 0-0x7ff, host reads and writes.
// - early data entry i low half maps to cell i.
// - late data entry i maps halves to cells 2i and 2i+1.
// - select picks by predicate, move copies; predicate is bit 0.
// - add, sub, reverse sub truncated to 16 bits, predicate bit 0.
// - late signed and unsigned rounding averages, predicate bit 0.
// - signed greater, less, equal compares write predicate only.
// - setlep tests 0..src2 range; early setzero tests both zero.
// - clamp src1 into 0..src2, predicate flags clamping.
// - clamp src1 into signed range of width b+1, flag clamping.
// - sign extend from bit b, predicate is bit b.
// - optional negate, then and, or, write or discard predicate.
`timescale 1ns/1ps
`default_nettype none
`include "vmc_core_regs.svh"

module vmc_core #(
   parameter bit LATE_GEN = 1'b1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // host register port
   input wire logic [23:0] host_addr_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [31:0] host_wdata_i,
   output logic [31:0] host_rdata_o,
   output logic host_rvalid_o,
   // execution
   output logic halted_o,
   output logic [10:0] fetch_pc_o,
   output logic [39:0] instr_o,
   output logic instr_valid_o,
   // datapath request
   input wire logic alu_valid_i,
   input wire logic [4:0] opcode_field_i,
   input wire logic [15:0] src1_i,
   input wire logic [15:0] src2_i,
   input wire logic [15:0] lsrc_i,
   input wire logic pred_i,
   input wire logic predicate_negate_bit_i,
   input wire logic [1:0] predicate_write_mode_i,
   input wire logic pdst_old_i,
   // datapath result
   output logic [15:0] result_o,
   output logic result_we_o,
   output logic pdst_o,
   output logic pdst_we_o
);

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   localparam logic [23:0] CTRL_OFS =
      LATE_GEN ? `VMC_CTRL_OFS_LATE : `VMC_CTRL_OFS_EARLY;
   localparam logic [23:0] WIN_OFS =
      LATE_GEN ? `VMC_WIN_OFS_LATE : `VMC_WIN_OFS_EARLY;
   localparam logic [23:0] DATA_OFS =
      LATE_GEN ? `VMC_DATA_OFS_LATE : `VMC_DATA_OFS_EARLY;
   localparam logic [23:0] DATA_SPAN =
      LATE_GEN ? `VMC_DATA_SPAN_LATE : `VMC_DATA_SPAN_EARLY;

   logic halt_reg;
   logic [10:0] addr_reg;
   logic part_hi_reg;
   logic [31:0] shadow_reg;
   logic [10:0] pc_reg;
   vmc_core_pkg::vmc_exec_t state_reg;
   logic [23:0] data_off;
   logic is_ctrl;
   logic is_win;
   logic is_data;
   logic ctrl_wr;
   logic win_ok;
   logic win_wr;
   logic host_rd;
   logic [10:0] didx;

   logic [39:0] code_mem [`VMC_CODE_CELLS];
   logic [15:0] data_mem [`VMC_DATA_CELLS];

   // decode of the host access
   assign data_off = host_addr_i - DATA_OFS;
   assign is_ctrl = (host_addr_i == CTRL_OFS);
   assign is_win = (host_addr_i == WIN_OFS);
   assign is_data = (data_off < DATA_SPAN) && !is_ctrl && !is_win;
   assign didx = data_off[12:2];
   assign ctrl_wr = host_wr_i && is_ctrl;
   assign host_rd = host_rd_i && !host_wr_i;
   assign win_ok = is_win && (host_wr_i || host_rd_i) && halt_reg;
   assign win_wr = win_ok && host_wr_i;
   assign halted_o = halt_reg;

   // ------------------------------------------------------------
   // code port control
   // ------------------------------------------------------------
   // halt bit
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         halt_reg <= `VMC_HALT_RST;
      end else if (ctrl_wr) begin
         halt_reg <= host_wdata_i[`VMC_HALT_BIT];
      end
   end

   // window cell address
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         addr_reg <= `VMC_ADDR_RST;
      end else if (ctrl_wr) begin
         addr_reg <= host_wdata_i[`VMC_ADDR_MSB:`VMC_ADDR_LSB];
      end else if (win_ok) begin
         if (LATE_GEN || part_hi_reg) begin
            addr_reg <= addr_reg + 11'h001;
         end
      end
   end

   // low/high part toggle
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         part_hi_reg <= 1'b0;
      end else if (ctrl_wr) begin
         part_hi_reg <= 1'b0;
      end else if (win_ok && !LATE_GEN) begin
         part_hi_reg <= !part_hi_reg;
      end
   end

   // write shadow for the low part
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         shadow_reg <= 32'h00000000;
      end else if (win_wr && !LATE_GEN && !part_hi_reg) begin
         shadow_reg <= host_wdata_i;
      end
   end

   // code store writes
   always_ff @(posedge clk_sys_i) begin
      if (win_wr) begin
         if (LATE_GEN) begin
            code_mem[addr_reg] <= {10'h000, host_wdata_i[29:0]};
         end else if (part_hi_reg) begin
            code_mem[addr_reg] <= {host_wdata_i[7:0], shadow_reg};
         end
      end
   end

   // ------------------------------------------------------------
   // data window
   // ------------------------------------------------------------
   // data store writes
   always_ff @(posedge clk_sys_i) begin
      if (host_wr_i && is_data) begin
         if (LATE_GEN) begin
            data_mem[{didx[9:0], 1'b0}] <= host_wdata_i[15:0];
            data_mem[{didx[9:0], 1'b1}] <= host_wdata_i[31:16];
         end else begin
            data_mem[didx] <= host_wdata_i[15:0];
         end
      end
   end

   // host read data, one cycle after the strobe
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         host_rdata_o <= 32'h00000000;
      end else if (host_rd) begin
         if (is_ctrl) begin
            host_rdata_o <= {15'h0000, halt_reg, 5'h00, addr_reg};
         end else if (win_ok && LATE_GEN) begin
            host_rdata_o <= {2'h0, code_mem[addr_reg][29:0]};
         end else if (win_ok && part_hi_reg) begin
            host_rdata_o <= {24'h000000, code_mem[addr_reg][39:32]};
         end else if (win_ok) begin
            host_rdata_o <= code_mem[addr_reg][31:0];
         end else if (is_data && LATE_GEN) begin
            host_rdata_o <= {data_mem[{didx[9:0], 1'b1}],
                             data_mem[{didx[9:0], 1'b0}]};
         end else if (is_data) begin
            host_rdata_o <= {16'h0000, data_mem[didx]};
         end else begin
            host_rdata_o <= 32'h00000000; // unmapped or gated window
         end
      end
   end

   // read answer strobe
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         host_rvalid_o <= 1'b0;
      end else begin
         host_rvalid_o <= host_rd;
      end
   end

   // ------------------------------------------------------------
   // execution control and fetch
   // ------------------------------------------------------------
   // run state and program counter
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= vmc_core_pkg::VMC_HALTED;
         pc_reg <= `VMC_PC_START;
      end else if (ctrl_wr && !host_wdata_i[`VMC_HALT_BIT]) begin
         if (halt_reg) begin
            state_reg <= vmc_core_pkg::VMC_RUNNING;
            pc_reg <= `VMC_PC_START;
         end
      end else if (ctrl_wr) begin
         state_reg <= vmc_core_pkg::VMC_HALTED;
      end else if (state_reg == vmc_core_pkg::VMC_RUNNING) begin
         pc_reg <= pc_reg + 11'h001;
      end
   end

   // fetched instruction
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         instr_o <= 40'h0000000000;
         fetch_pc_o <= 11'h000;
         instr_valid_o <= 1'b0;
      end else begin
         unique case (state_reg)
            vmc_core_pkg::VMC_RUNNING: begin
               instr_o <= code_mem[pc_reg];
               fetch_pc_o <= pc_reg;
               instr_valid_o <= !ctrl_wr;
            end
            vmc_core_pkg::VMC_HALTED: begin
               instr_valid_o <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   logic [15:0] alu_res;
   logic alu_pres;
   logic alu_dst;
   logic alu_known;
   logic [16:0] s1;
   logic [16:0] s2;
   logic [16:0] sum_s;
   logic [16:0] sum_u;
   logic [16:0] lim_hi;
   logic [16:0] lim_lo;
   logic [15:0] ext_mask;
   logic [3:0] bsel;

   // operation results
   always_comb begin
      s1 = {src1_i[15], src1_i};
      s2 = {src2_i[15], src2_i};
      bsel = 4'(src2_i & `VMC_BIT_MASK);
      sum_s = s1 + s2 + 17'h00001;
      sum_u = {1'b0, src1_i} + {1'b0, src2_i} + 17'h00001;
      lim_hi = (17'h00001 << bsel) - 17'h00001;
      lim_lo = ~lim_hi;
      ext_mask = 16'hffff << bsel;
      alu_res = 16'h0000;
      alu_pres = 1'b0;
      alu_dst = 1'b1;
      alu_known = 1'b1;
      unique case (opcode_field_i)
         vmc_core_pkg::VMC_OP_SELECT: begin
            alu_res = pred_i ? src1_i : src2_i;
            alu_pres = alu_res[0];
         end
         vmc_core_pkg::VMC_OP_MOVE: begin
            alu_res = lsrc_i;
            alu_pres = alu_res[0];
         end
         vmc_core_pkg::VMC_OP_ADD: begin
            alu_res = src1_i + src2_i;
            alu_pres = alu_res[0];
         end
         vmc_core_pkg::VMC_OP_SUB: begin
            alu_res = src1_i - src2_i;
            alu_pres = alu_res[0];
         end
         vmc_core_pkg::VMC_OP_SUBR_AVGS: begin
            alu_res = LATE_GEN ? sum_s[16:1] : src2_i - src1_i;
            alu_pres = alu_res[0];
         end
         vmc_core_pkg::VMC_OP_AVGU: begin
            alu_res = sum_u[16:1];
            alu_pres = alu_res[0];
            alu_known = LATE_GEN;
         end
         vmc_core_pkg::VMC_OP_SETGT: begin
            alu_pres = $signed(s1) > $signed(s2);
            alu_dst = 1'b0;
         end
         vmc_core_pkg::VMC_OP_SETLT: begin
            alu_pres = $signed(s1) < $signed(s2);
            alu_dst = 1'b0;
         end
         vmc_core_pkg::VMC_OP_SETEQ: begin
            alu_pres = src1_i == src2_i;
            alu_dst = 1'b0;
         end
         vmc_core_pkg::VMC_OP_SETLEP: begin
            alu_pres = ($signed(s1) <= $signed(s2)) && !src1_i[15];
            alu_dst = 1'b0;
         end
         vmc_core_pkg::VMC_OP_SETZERO: begin
            alu_pres = (src1_i == 16'h0000) && (src2_i == 16'h0000);
            alu_dst = 1'b0;
            alu_known = !LATE_GEN;
         end
         vmc_core_pkg::VMC_OP_CLAMPLEP: begin
            alu_res = src1_i;
            if (src1_i[15]) begin
               alu_res = 16'h0000;
               alu_pres = 1'b1;
            end
            if ($signed(s1) > $signed(s2)) begin
               alu_res = src2_i;
               alu_pres = 1'b1;
            end
         end
         vmc_core_pkg::VMC_OP_CLAMPS: begin
            alu_res = src1_i;
            if ($signed(s1) < $signed(lim_lo)) begin
               alu_res = lim_lo[15:0];
               alu_pres = 1'b1;
            end
            if ($signed(s1) > $signed(lim_hi)) begin
               alu_res = lim_hi[15:0];
               alu_pres = 1'b1;
            end
         end
         vmc_core_pkg::VMC_OP_SIGNEXT: begin
            alu_pres = src1_i[bsel];
            alu_res = alu_pres ? (src1_i | ext_mask) : (src1_i & ~ext_mask);
         end
         default: begin
            alu_known = 1'b0; // opcodes outside this datapath
         end
      endcase
   end

   // registered datapath outputs
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         result_o <= 16'h0000;
         result_we_o <= 1'b0;
         pdst_o <= 1'b0;
         pdst_we_o <= 1'b0;
      end else begin
         result_o <= alu_res;
         result_we_o <= alu_valid_i && alu_known && alu_dst;
         unique case (vmc_core_pkg::vmc_pmode_t'(predicate_write_mode_i))
            vmc_core_pkg::VMC_PM_AND:
               pdst_o <= pdst_old_i & (alu_pres ^ predicate_negate_bit_i);
            vmc_core_pkg::VMC_PM_OR:
               pdst_o <= pdst_old_i | (alu_pres ^ predicate_negate_bit_i);
            vmc_core_pkg::VMC_PM_WRITE:
               pdst_o <= alu_pres ^ predicate_negate_bit_i;
            vmc_core_pkg::VMC_PM_DISCARD:
               pdst_o <= pdst_old_i;
         endcase
         pdst_we_o <= alu_valid_i && alu_known &&
            (predicate_write_mode_i != vmc_core_pkg::VMC_PM_DISCARD);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_run_from_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctrl_wr && halt_reg && !host_wdata_i[`VMC_HALT_BIT]) ##1 !ctrl_wr
      |=> instr_valid_o && fetch_pc_o == 11'h000)
      else $error("execution did not start at address zero");
   a_halt_stops: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ctrl_wr && host_wdata_i[`VMC_HALT_BIT]) |=> ##1 !instr_valid_o[*3])
      else $error("fetch continued after halt");
   a_gate_window: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (is_win && (host_wr_i || host_rd_i) && !halt_reg) |=> $stable(addr_reg))
      else $error("window acted while running");
   a_late_incr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (LATE_GEN && win_ok && !ctrl_wr)
      |=> addr_reg == $past(addr_reg) + 11'h001)
      else $error("late window address did not advance");
   a_ctrl_toggle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ctrl_wr |=> !part_hi_reg)
      else $error("toggle not cleared by control write");
   a_low_part: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!LATE_GEN && win_ok && !part_hi_reg && !ctrl_wr)
      |=> part_hi_reg && $stable(addr_reg))
      else $error("low part access wrong");
   a_high_part: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!LATE_GEN && win_ok && part_hi_reg && !ctrl_wr)
      |=> !part_hi_reg && addr_reg == $past(addr_reg) + 11'h001)
      else $error("high part access wrong");
   a_cmp_no_dst: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (alu_valid_i && opcode_field_i[4:2] == 3'h2) |=> !result_we_o)
      else $error("compare wrote a destination");
   a_add_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (alu_valid_i && opcode_field_i == vmc_core_pkg::VMC_OP_ADD)
      |=> result_we_o && result_o == $past(src1_i) + $past(src2_i))
      else $error("add result wrong");
   a_pred_discard: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (predicate_write_mode_i == vmc_core_pkg::VMC_PM_DISCARD) |=> !pdst_we_o)
      else $error("discarded predicate was written");

endmodule : vmc_core
`default_nettype wire

//--- core/vmc_core_pkg.sv
package vmc_core_pkg;
   // base opcode encodings of the datapath
   typedef enum logic [4:0] {
      VMC_OP_SELECT = 5'h00,
      VMC_OP_MOVE = 5'h01,
      VMC_OP_ADD = 5'h04,
      VMC_OP_SUB = 5'h05,
      VMC_OP_SUBR_AVGS = 5'h06,
      VMC_OP_AVGU = 5'h07,
      VMC_OP_SETGT = 5'h08,
      VMC_OP_SETLT = 5'h09,
      VMC_OP_SETEQ = 5'h0a,
      VMC_OP_SETLEP = 5'h0b,
      VMC_OP_CLAMPLEP = 5'h0c,
      VMC_OP_CLAMPS = 5'h0d,
      VMC_OP_SIGNEXT = 5'h0e,
      VMC_OP_SETZERO = 5'h0f
   } vmc_opcode_t;
   // predicate write modes
   typedef enum logic [1:0] {
      VMC_PM_AND = 2'h0,
      VMC_PM_OR = 2'h1,
      VMC_PM_WRITE = 2'h2,
      VMC_PM_DISCARD = 2'h3
   } vmc_pmode_t;
   // execution state
   typedef enum logic {
      VMC_HALTED,
      VMC_RUNNING
   } vmc_exec_t;
endpackage : vmc_core_pkg

//--- core/vmc_core_regs.svh
`ifndef VMC_CORE_REGS_SVH
`define VMC_CORE_REGS_SVH
// host register offsets, first generation
`define VMC_DATA_OFS_EARLY 24'h103200
`define VMC_CTRL_OFS_EARLY 24'h103288
`define VMC_WIN_OFS_EARLY 24'h10328c
// host register offsets, later generations
`define VMC_DATA_OFS_LATE 24'h085400
`define VMC_CTRL_OFS_LATE 24'h085440
`define VMC_WIN_OFS_LATE 24'h085444
// data window span in bytes (entries times four)
`define VMC_DATA_SPAN_EARLY 24'h002000
`define VMC_DATA_SPAN_LATE 24'h001000
// control register fields
`define VMC_ADDR_LSB 0
`define VMC_ADDR_MSB 10
`define VMC_HALT_BIT 16
// reset values
`define VMC_HALT_RST 1'b1
`define VMC_ADDR_RST 11'h000
`define VMC_PC_START 11'h000
// store geometry
`define VMC_CODE_CELLS 2048
`define VMC_DATA_CELLS 2048
`define VMC_CELL_W_EARLY 40
`define VMC_CELL_W_LATE 30
`define VMC_LOW_PART_W 32
`define VMC_HIGH_PART_W 8
// clamp / sign extension bit field mask
`define VMC_BIT_MASK 16'h000f
`endif

//--- tb/vmc_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vmc_core_regs.svh"
module vmc_core_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [23:0] addr;
   logic wr, rd, rv, halted, ivalid, av, pr, ng, pold, rwe, pdst, pwe;
   logic [31:0] wd, rdat, d;
   logic [10:0] pc;
   logic [39:0] instr;
   logic [4:0] op;
   logic [1:0] pm;
   logic [15:0] s1, s2, ls, res;
   logic [23:0] e_addr;
   logic e_wr, e_rd, e_rv, e_rwe, e_pdst, e_pwe;
   logic [31:0] e_wd, e_rdat;
   logic [15:0] e_res;
   int fails = 0;
   int tests_run = 0;
   // clock, 5 ns period
   always #2.5 clk = ~clk;
   vmc_host_model i_host (.clk_sys_i(clk), .host_rdata_i(rdat),
      .host_rvalid_i(rv), .host_addr_o(addr), .host_wr_o(wr),
      .host_rd_o(rd), .host_wdata_o(wd));
   vmc_core #(.LATE_GEN(1'b1)) i_dut (.clk_sys_i(clk), .rst_i(rst),
      .host_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd),
      .host_wdata_i(wd), .host_rdata_o(rdat), .host_rvalid_o(rv),
      .halted_o(halted), .fetch_pc_o(pc), .instr_o(instr),
      .instr_valid_o(ivalid), .alu_valid_i(av), .opcode_field_i(op),
      .src1_i(s1), .src2_i(s2), .lsrc_i(ls), .pred_i(pr),
      .predicate_negate_bit_i(ng), .predicate_write_mode_i(pm),
      .pdst_old_i(pold), .result_o(res), .result_we_o(rwe),
      .pdst_o(pdst), .pdst_we_o(pwe));
   // first generation instance, shares the datapath stimulus
   vmc_host_model i_host_e (.clk_sys_i(clk), .host_rdata_i(e_rdat),
      .host_rvalid_i(e_rv), .host_addr_o(e_addr), .host_wr_o(e_wr),
      .host_rd_o(e_rd), .host_wdata_o(e_wd));
   vmc_core #(.LATE_GEN(1'b0)) i_dut_early (.clk_sys_i(clk), .rst_i(rst),
      .host_addr_i(e_addr), .host_wr_i(e_wr), .host_rd_i(e_rd),
      .host_wdata_i(e_wd), .host_rdata_o(e_rdat), .host_rvalid_o(e_rv),
      .halted_o(), .fetch_pc_o(), .instr_o(), .instr_valid_o(),
      .alu_valid_i(av), .opcode_field_i(op), .src1_i(s1), .src2_i(s2),
      .lsrc_i(ls), .pred_i(pr), .predicate_negate_bit_i(ng),
      .predicate_write_mode_i(pm), .pdst_old_i(pold), .result_o(e_res),
      .result_we_o(e_rwe), .pdst_o(e_pdst), .pdst_we_o(e_pwe));
   // compare and count
   task automatic chk(input string nm, input logic [39:0] e,
                      input logic [39:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic test_reset();
      chk("halted", 40'h1, {39'h0, halted});
      i_host.rd(`VMC_CTRL_OFS_LATE, d);
      chk("ctrl", 40'h10000, {8'h0, d});
      $display("test reset done");
   endtask : test_reset
   // window writes wrap the address past the top cell
   task automatic test_window();
      i_host.wr(`VMC_CTRL_OFS_LATE, 32'h000107fe);
      i_host.wr(`VMC_WIN_OFS_LATE, 32'hc1234567);
      i_host.wr(`VMC_WIN_OFS_LATE, 32'h2aaa5555);
      i_host.rd(`VMC_CTRL_OFS_LATE, d);
      chk("ctrl addr", 40'h10000, {8'h0, d});
      i_host.wr(`VMC_CTRL_OFS_LATE, 32'h000107fe);
      i_host.rd(`VMC_WIN_OFS_LATE, d);
      chk("cell 7fe", 40'h01234567, {8'h0, d});
      i_host.rd(`VMC_WIN_OFS_LATE, d);
      chk("cell 7ff", 40'h2aaa5555, {8'h0, d});
      i_host.rd(24'h000000, d);
      chk("unmapped", 40'h0, {8'h0, d});
      $display("test window done");
   endtask : test_window
   task automatic test_data();
      i_host.wr(`VMC_DATA_OFS_LATE + 24'hffc, 32'hbeef1234);
      i_host.wr(`VMC_DATA_OFS_LATE, 32'h00010002);
      i_host.rd(`VMC_DATA_OFS_LATE + 24'hffc, d);
      chk("data top", 40'hbeef1234, {8'h0, d});
      i_host.rd(`VMC_DATA_OFS_LATE, d);
      chk("data 0", 40'h00010002, {8'h0, d});
      i_host.rd(`VMC_DATA_OFS_LATE + `VMC_DATA_SPAN_LATE, d);
      chk("past data", 40'h0, {8'h0, d});
      $display("test data done");
   endtask : test_data
   // first generation: split window, single data cells, subr, setzero
   task automatic test_early();
      i_host_e.wr(`VMC_CTRL_OFS_EARLY, 32'h00010005);
      i_host_e.wr(`VMC_WIN_OFS_EARLY, 32'h89abcdef);
      i_host_e.rd(`VMC_CTRL_OFS_EARLY, d);
      chk("early addr lo", 40'h10005, {8'h0, d});
      i_host_e.wr(`VMC_WIN_OFS_EARLY, 32'hffffff5a);
      i_host_e.rd(`VMC_CTRL_OFS_EARLY, d);
      chk("early addr hi", 40'h10006, {8'h0, d});
      i_host_e.wr(`VMC_CTRL_OFS_EARLY, 32'h00010005);
      i_host_e.rd(`VMC_WIN_OFS_EARLY, d);
      chk("early first", 40'h89abcdef, {8'h0, d});
      i_host_e.wr(`VMC_CTRL_OFS_EARLY, 32'h00010005);
      i_host_e.rd(`VMC_WIN_OFS_EARLY, d);
      chk("early low", 40'h89abcdef, {8'h0, d});
      i_host_e.rd(`VMC_WIN_OFS_EARLY, d);
      chk("early high", 40'h5a, {8'h0, d});
      i_host_e.wr(`VMC_DATA_OFS_EARLY + 24'h1ffc, 32'hbeef1234);
      i_host_e.rd(`VMC_DATA_OFS_EARLY + 24'h1ffc, d);
      chk("early data", 40'h1234, {8'h0, d});
      alu(5'h06, 16'h3, 16'h5, 16'h0, 5'h04, 16'h4, 3'b101);
      chk("early subr", 40'h2, {24'h0, e_res});
      @(negedge clk);
      {op, s1, s2, av} = {5'h0f, 16'h0, 16'h0, 1'b1};
      @(negedge clk);
      av = 1'b0;
      chk("late 0f", 40'h0, {38'h0, rwe, pwe});
      chk("early zero", 40'h3, {37'h0, e_rwe, e_pdst, e_pwe});
      $display("test early done");
   endtask : test_early
   // start from cell 0, window dead while running, then halt
   task automatic test_run();
      i_host.wr(`VMC_CTRL_OFS_LATE, 32'h00010000);
      i_host.wr(`VMC_WIN_OFS_LATE, 32'h3abcdef1);
      i_host.wr(`VMC_CTRL_OFS_LATE, 32'h00000000);
      for (int n = 0; n < 6 && ivalid !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk("pc0", 40'h0, {29'h0, pc});
      chk("instr0", 40'h003abcdef1, instr);
      @(negedge clk);
      chk("pc1", 40'h1, {29'h0, pc});
      i_host.rd(`VMC_WIN_OFS_LATE, d);
      chk("win running", 40'h0, {8'h0, d});
      i_host.wr(`VMC_CTRL_OFS_LATE, 32'h00010000);
      @(negedge clk);
      chk("stopped", 40'h2, {38'h0, halted, ivalid});
      $display("test run done");
   endtask : test_run
   // c = {pred, negate, mode, old}; ef = {result we, pdst, pdst we}
   task automatic alu(input logic [4:0] o, input logic [15:0] a, b, l,
      input logic [4:0] c, input logic [15:0] er, input logic [2:0] ef);
      @(negedge clk);
      {op, s1, s2, ls, av} = {o, a, b, l, 1'b1};
      {pr, ng, pm, pold} = c;
      @(negedge clk);
      av = 1'b0;
      chk("alu flags", {37'h0, ef}, {37'h0, rwe, pdst, pwe});
      if (ef[2]) chk("alu result", {24'h0, er}, {24'h0, res});
   endtask : alu
   task automatic test_alu();
      alu(5'h04, 16'h7fff, 16'h0001, 16'h0, 5'h04, 16'h8000, 3'b101);
      alu(5'h05, 16'h0003, 16'h0005, 16'h0, 5'h04, 16'hfffe, 3'b101);
      alu(5'h06, 16'hfffd, 16'h0000, 16'h0, 5'h04, 16'hffff, 3'b111);
      alu(5'h07, 16'hffff, 16'h0001, 16'h0, 5'h04, 16'h8000, 3'b101);
      alu(5'h00, 16'h0011, 16'h0022, 16'h0, 5'h04, 16'h0022, 3'b101);
      alu(5'h00, 16'h0011, 16'h0022, 16'h0, 5'h14, 16'h0011, 3'b111);
      alu(5'h01, 16'h0, 16'h0, 16'h1235, 5'h04, 16'h1235, 3'b111);
      alu(5'h08, 16'h0001, 16'hffff, 16'h0, 5'h04, 16'h0, 3'b011);
      alu(5'h09, 16'h0001, 16'hffff, 16'h0, 5'h0c, 16'h0, 3'b011);
      alu(5'h0a, 16'h0007, 16'h0007, 16'h0, 5'h00, 16'h0, 3'b001);
      alu(5'h0a, 16'h0007, 16'h0007, 16'h0, 5'h01, 16'h0, 3'b011);
      alu(5'h0b, 16'h0005, 16'h0005, 16'h0, 5'h02, 16'h0, 3'b011);
      alu(5'h0b, 16'hffff, 16'h0005, 16'h0, 5'h04, 16'h0, 3'b001);
      alu(5'h0c, 16'h0009, 16'h0004, 16'h0, 5'h04, 16'h0004, 3'b111);
      alu(5'h0c, 16'h8000, 16'h0004, 16'h0, 5'h04, 16'h0000, 3'b111);
      alu(5'h0d, 16'h0100, 16'h0013, 16'h0, 5'h04, 16'h0007, 3'b111);
      alu(5'h0d, 16'h0003, 16'h0013, 16'h0, 5'h04, 16'h0003, 3'b101);
      alu(5'h0e, 16'h0018, 16'h0004, 16'h0, 5'h04, 16'hfff8, 3'b111);
      alu(5'h04, 16'h0001, 16'h0001, 16'h0, 5'h07, 16'h0002, 3'b110);
      $display("test alu done");
   endtask : test_alu
   // watchdog, well past the expected run length
   initial begin
      #100000;
      fails++;
      stop_test();
   end
   // main sequence
   initial begin
      {av, op, s1, s2, ls, pr, ng, pm, pold} = '0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      test_reset();
      test_window();
      test_data();
      test_early();
      test_run();
      test_alu();
      stop_test();
   end
endmodule : vmc_core_tb_top
`default_nettype wire

//--- tb/vmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vmc_host_model (
   // clock
   input wire logic clk_sys_i,
   // register answers
   input wire logic [31:0] host_rdata_i,
   input wire logic host_rvalid_i,
   // register requests
   output logic [23:0] host_addr_o,
   output logic host_wr_o,
   output logic host_rd_o,
   output logic [31:0] host_wdata_o
);
   // idle bus from time zero
   initial begin
      {host_addr_o, host_wr_o, host_rd_o, host_wdata_o} = '0;
   end
   // one write strobe, then data toggles so stale data never looks valid
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      @(negedge clk_sys_i);
      {host_addr_o, host_wdata_o, host_wr_o} = {a, d, 1'b1};
      @(negedge clk_sys_i);
      host_wr_o = 1'b0;
      host_wdata_o = ~d;
   endtask : wr
   // one read strobe, answer taken when rvalid shows, bounded wait
   task automatic rd(input logic [23:0] a, output logic [31:0] d);
      @(negedge clk_sys_i);
      {host_addr_o, host_rd_o} = {a, 1'b1};
      @(negedge clk_sys_i);
      host_rd_o = 1'b0;
      for (int n = 0; n < 3 && host_rvalid_i !== 1'b1; n++) begin
         @(negedge clk_sys_i);
      end
      d = (host_rvalid_i === 1'b1) ? host_rdata_i : 'x;
   endtask : rd
endmodule : vmc_host_model
`default_nettype wire
